// >>> dbm_pkg.sv
// Function
// [R01] Monitor outputs driven only when enable set
// [R02] Payload indicator high for AAL-5 payload words
// [R03] Payload indicator changes only at attention fall
// [R04] Last-word indicator marks packet or buffer end
// [R05] First-cell indicator marks first cell last word
// [R06] Remaining-cells indicator when count at or below threshold
// [R07] Channel-watch indicator follows channel watch flag
// [R08] Channel-watch indicator updates at attention fall
// [R09] Attention falling edge is the update reference
// [R10] All monitor outputs registered on rising clock
package dbm_pkg;

  localparam int  DBM_CNT_W     = 8;
  localparam logic DBM_RST_LVL  = 1'h0;
  localparam logic DBM_ATTN_IDLE = 1'h1;
  localparam logic [4:0] DBM_OE_RST = 5'h00;

endpackage : dbm_pkg

// >>> dbm_monitor.sv
`timescale 1ns/100ps
module dbm_monitor
  import dbm_pkg::*;
#(
  parameter int CNT_W = DBM_CNT_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Mode
  input  wire logic             monitor_enable_bit,
  input  wire logic [CNT_W-1:0] remaining_cell_threshold,
  input  wire logic [CNT_W-1:0] tx_cells_left,
  // DMA engine status, same clock
  input  wire logic             dma_attention_n,
  input  wire logic             dma_word_valid,
  input  wire logic             word_is_aal5_payload,
  input  wire logic             word_is_packet_last,
  input  wire logic             word_is_buffer_last,
  input  wire logic             word_is_overflow_last,
  input  wire logic             word_is_first_cell_last,
  input  wire logic             channel_watch_flag,
  // Monitor pins
  output logic                  payload_indicator,
  output logic                  last_word_indicator,
  output logic                  first_cell_indicator,
  output logic                  remaining_cells_indicator,
  output logic                  channel_watch_indicator,
  output logic [4:0]            monitor_oe
);

  ////////////////////////////////////////////////////////////////
  // Attention edge
  ////////////////////////////////////////////////////////////////
  logic attn_d_ff;
  logic nxt_attn_d;
  logic attn_fall;

  always_comb begin
    nxt_attn_d = dma_attention_n;
    // Engine drives this line from clk, so no sync stages
    // Back-to-back cycles need the line high for one clock
    attn_fall  = attn_d_ff & ~dma_attention_n; // [R09]
  end

  // Idle history, so a line already low when reset ends reads as a fall
  dbm_pin_flop #(
    .W       (1),
    .RST_VAL (DBM_ATTN_IDLE)
  ) u_attn_hist (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_attn_d),
    .q     (attn_d_ff)
  );

  ////////////////////////////////////////////////////////////////
  // Payload indicator
  ////////////////////////////////////////////////////////////////
  logic nxt_payload;

  always_comb begin
    nxt_payload = payload_indicator;
    // Low for every other kind of word moved
    if (attn_fall) begin
      // Taken once per DMA cycle, held to the next fall
      nxt_payload = word_is_aal5_payload; // [R02] [R03]
    end
  end

  dbm_pin_flop #(
    .W       (1),
    .RST_VAL (DBM_RST_LVL)
  ) u_payload_reg (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_payload),
    .q     (payload_indicator)
  );

  ////////////////////////////////////////////////////////////////
  // Channel-watch indicator
  ////////////////////////////////////////////////////////////////
  logic nxt_watch;

  always_comb begin
    nxt_watch = channel_watch_indicator;
    // Held until the next fall, not to the cycle end
    if (attn_fall) begin
      // Flag of the channel that opens this cycle
      nxt_watch = channel_watch_flag; // [R07] [R08]
    end
  end

  dbm_pin_flop #(
    .W       (1),
    .RST_VAL (DBM_RST_LVL)
  ) u_watch_reg (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_watch),
    .q     (channel_watch_indicator)
  );

  ////////////////////////////////////////////////////////////////
  // Last-word indicator
  ////////////////////////////////////////////////////////////////
  logic word_end_hit;
  logic nxt_last;

  always_comb begin
    word_end_hit = word_is_packet_last
                 | word_is_buffer_last
                 | word_is_overflow_last;
    // Qualifiers alone never pulse; a word must move
    nxt_last     = dma_word_valid & word_end_hit; // [R04]
  end

  dbm_pin_flop #(
    .W       (1),
    .RST_VAL (DBM_RST_LVL)
  ) u_last_reg (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_last),
    .q     (last_word_indicator)
  );

  ////////////////////////////////////////////////////////////////
  // First-cell indicator
  ////////////////////////////////////////////////////////////////
  logic word_first_hit;
  logic nxt_first;

  always_comb begin
    word_first_hit = word_is_first_cell_last;
    // Same gating as the last-word pulse
    nxt_first      = dma_word_valid & word_first_hit; // [R05]
  end

  dbm_pin_flop #(
    .W       (1),
    .RST_VAL (DBM_RST_LVL)
  ) u_first_reg (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_first),
    .q     (first_cell_indicator)
  );

  ////////////////////////////////////////////////////////////////
  // Remaining-cells indicator
  ////////////////////////////////////////////////////////////////
  logic nxt_remain;

  always_comb begin
    // Equal already counts as low fill
    // Threshold writes show one clock later
    nxt_remain = (tx_cells_left <= remaining_cell_threshold); // [R06]
  end

  dbm_pin_flop #(
    .W       (1),
    .RST_VAL (DBM_RST_LVL)
  ) u_remain_reg (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_remain),
    .q     (remaining_cells_indicator)
  );

  ////////////////////////////////////////////////////////////////
  // Output enables
  ////////////////////////////////////////////////////////////////
  logic [4:0] nxt_oe;

  always_comb begin
    // Indicators run on; only the enables reach the pins
    for (int i = 0; i < 5; i++) begin
      nxt_oe[i] = monitor_enable_bit; // [R01]
    end
  end

  dbm_pin_flop #(
    .W       (5),
    .RST_VAL (DBM_OE_RST)
  ) u_oe_reg (
    .clk   (clk),
    .reset (reset),
    .d     (nxt_oe),
    .q     (monitor_oe)
  );

endmodule : dbm_monitor

////////////////////////////////////////////////////////////////
// Shared clocked register
////////////////////////////////////////////////////////////////
module dbm_pin_flop
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Next value
  input  wire logic [W-1:0] d,
  // Registered value
  output logic      [W-1:0] q
);

  // Reset loads a constant only, never a signal
  always_ff @(posedge clk or posedge reset) begin // [R10]
    if (reset) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

endmodule : dbm_pin_flop

// >>> dbm_monitor_sva.sv
`timescale 1ns/100ps
module dbm_sva
  import dbm_pkg::*;
(
  input logic                 clk,
  input logic                 reset,
  input logic                 monitor_enable_bit,
  input logic [DBM_CNT_W-1:0] remaining_cell_threshold,
  input logic [DBM_CNT_W-1:0] tx_cells_left,
  input logic                 dma_attention_n,
  input logic                 dma_word_valid,
  input logic                 word_is_aal5_payload,
  input logic                 word_is_packet_last,
  input logic                 word_is_buffer_last,
  input logic                 word_is_overflow_last,
  input logic                 word_is_first_cell_last,
  input logic                 channel_watch_flag,
  input logic                 payload_indicator,
  input logic                 last_word_indicator,
  input logic                 first_cell_indicator,
  input logic                 remaining_cells_indicator,
  input logic                 channel_watch_indicator,
  input logic [4:0]           monitor_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_oe_follow_en: assert property (
    ##1 monitor_oe == {5{$past(monitor_enable_bit)}})
    else $error("pin enables do not follow the enable bit");
  a_pay_at_fall: assert property (
    $fell(dma_attention_n) |=> payload_indicator == $past(word_is_aal5_payload))
    else $error("payload flag not taken at attention fall");
  a_pay_hold: assert property (
    dma_attention_n |=> $stable(payload_indicator))
    else $error("payload indicator moved without attention fall");
  a_watch_at_fall: assert property (
    $fell(dma_attention_n) |=> channel_watch_indicator == $past(channel_watch_flag))
    else $error("watch flag not taken at attention fall");
  a_watch_hold: assert property (
    dma_attention_n |=> $stable(channel_watch_indicator))
    else $error("watch indicator moved without attention fall");
  a_last_pulse: assert property (
    ##1 last_word_indicator == $past(dma_word_valid && (word_is_packet_last || word_is_buffer_last
      || word_is_overflow_last)))
    else $error("last-word pulse wrong");
  a_first_pulse: assert property (
    ##1 first_cell_indicator == $past(dma_word_valid && word_is_first_cell_last))
    else $error("first-cell pulse wrong");
  a_remain_cmp: assert property (
    ##1 remaining_cells_indicator == $past(tx_cells_left <= remaining_cell_threshold))
    else $error("remaining-cells indicator wrong");
endmodule : dbm_sva

// >>> dbm_observer.sv
`timescale 1ns/100ps
module dbm_observer(input logic [4:0] oe,v,output wire [4:0] pin);
  for (genvar i = 0; i < 5; i++) begin : g_pin
    assign pin[i] = oe[i] ? v[i] : 1'bz;
  end
endmodule : dbm_observer

// >>> dbm_monitor_test.sv
`timescale 1ns/100ps
module dbm_monitor_test;
  logic clk=0,rst=1,en=0,an=1,vl=0,py=0,pl=0,bl=0,ol=0,fl=0,wf=0;
  logic [7:0] th=8'h04,lf=8'h10;
  logic [4:0] q,oe;
  wire [4:0] p;
  int err_count=0,total_checks=0;
  dbm_monitor dut(.clk,.reset(rst),.monitor_enable_bit(en),.remaining_cell_threshold(th),.tx_cells_left(lf),
    .dma_attention_n(an),.dma_word_valid(vl),.word_is_aal5_payload(py),.word_is_packet_last(pl),
    .word_is_buffer_last(bl),.word_is_overflow_last(ol),.word_is_first_cell_last(fl),.channel_watch_flag(wf),
    .payload_indicator(q[0]),.last_word_indicator(q[1]),.first_cell_indicator(q[2]),
    .remaining_cells_indicator(q[3]),.channel_watch_indicator(q[4]),.monitor_oe(oe));
  dbm_observer obs(.oe,.v(q),.pin(p));
  initial forever #5 clk=~clk;
  task automatic ck(logic [4:0] e);
    @(posedge clk);
    #1;
    total_checks++;
    if (p !== e) begin
      err_count++;
      $display("mismatch %0t pins %b", $time, p);
    end
  endtask : ck
  task automatic t_fall;
    ck('z);
    @(posedge clk) {en, an, py, wf, lf} <= {4'hB, 8'h04};
    ck(5'h19);
    @(posedge clk) {an, py, wf, lf} <= {3'h4, 8'h05};
    ck(5'h11);
    @(posedge clk) an <= 1'b0;
    ck(5'h00);
    $display("fall done");
  endtask : t_fall
  task automatic t_last;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) {vl, fl, ol, bl, pl} <= {1'b1, i == 0, 3'h1 << i};
      ck({2'b00, i == 0, 2'b10});
    end
    @(posedge clk) {vl, fl} <= 2'b00;
    ck(5'h00);
    @(posedge clk) en <= 1'b0;
    ck('z);
    $display("last done");
  endtask : t_last
  task automatic finish_test;
    $display("checks %0d mismatches %0d",total_checks,err_count);
    if (err_count==0&&total_checks>0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge clk); rst<=0;
    t_fall;
    t_last;
    finish_test;
  end
endmodule : dbm_monitor_test
bind dbm_monitor dbm_sva chk(.*);
